// file: hw/bai_cfg.svh
// Purpose: shared constants for the bus arbitration and interrupt pin ends
// Assumes: included by its bare name
// Notes: pins are active low on the wire except the function codes and the core disable strap; levels are plain binary
`ifndef BAI_CFG_SVH
`define BAI_CFG_SVH

// ****************************************************************
// interrupt levels
// ****************************************************************
`define BAI_LEVEL_NONE 3'h0
`define BAI_LEVEL_ONE 3'h1
`define BAI_LEVEL_SIX 3'h6
`define BAI_LEVEL_SEVEN 3'h7

// ****************************************************************
// reset values and timing
// ****************************************************************
`define BAI_FC_RST 3'h0
`define BAI_PIN_IDLE 1'h1
`define BAI_HALT_SETTLE_CLKS 2'h2

`endif

// file: hw/bai_pkg.sv
// Purpose: types shared by both ends of the arbitration link
// Assumes: nothing
// Notes: state codes follow a Gray path along the usual transitions
package bai_pkg;

  typedef enum logic [2:0] {
    BAI_DEV_IDLE = 3'h0,
    BAI_DEV_INDEPENDENT_DMA_MASTER = 3'h1,
    BAI_DEV_SERIAL_DMA_MASTER = 3'h3,
    BAI_DEV_HALT = 3'h2,
    BAI_DEV_EXT = 3'h4
  } bai_dev_state_t;

  typedef enum logic [2:0] {
    BAI_HOST_IDLE = 3'h0,
    BAI_HOST_REQ = 3'h1,
    BAI_HOST_WAIT = 3'h3,
    BAI_HOST_OWN = 3'h2,
    BAI_HOST_HALT = 3'h6,
    BAI_HOST_SETTLE = 3'h7
  } bai_host_state_t;

endpackage

// file: hw/bai_link_if.sv
// Purpose: pins between the device and an external master or interrupt source
// Assumes: every line is pulled high when nobody drives it
// Notes: output enables are active low; the wire levels are resolved here
`timescale 1ns/1ps
interface bai_link_if;
  // device drives
  logic devBusGrantN;
  logic devGrantAckOut;
  logic devGrantAckOeN;
  logic devStrobeOut;
  logic devStrobeOeN;
  logic [2:0] devFcOut;
  logic devFcOeN;
  logic devAckOut;
  logic devAckOeN;
  logic [2:0] devWriteOut;
  logic devWriteOeN;
  // external party drives
  logic hostBusRequestOeN;
  logic hostHaltOeN;
  logic hostGrantAckOut;
  logic hostGrantAckOeN;
  logic hostStrobeOut;
  logic hostStrobeOeN;
  logic [2:0] hostFcOut;
  logic hostFcOeN;
  logic hostAckOut;
  logic hostAckOeN;
  logic [2:0] hostPriorityN;
  logic hostAutovectorN;
  logic hostCoreDisable;
  // resolved wires
  logic busRequestN;
  logic busGrantN;
  logic haltN;
  logic grantAckN;
  logic addressStrobeN;
  logic [2:0] functionCode;
  logic transferAckN;
  logic [2:0] writeStrobesN;
  logic [2:0] priorityN;
  logic autovectorN;
  logic coreDisablePin;

  assign busRequestN = hostBusRequestOeN;
  assign haltN = hostHaltOeN;
  assign busGrantN = devBusGrantN;
  assign grantAckN = !devGrantAckOeN ? devGrantAckOut :
                     (!hostGrantAckOeN ? hostGrantAckOut : 1'b1);
  assign addressStrobeN = !devStrobeOeN ? devStrobeOut :
                          (!hostStrobeOeN ? hostStrobeOut : 1'b1);
  assign functionCode = !devFcOeN ? devFcOut : (!hostFcOeN ? hostFcOut : 3'h7);
  assign transferAckN = !devAckOeN ? devAckOut : (!hostAckOeN ? hostAckOut : 1'b1);
  assign writeStrobesN = !devWriteOeN ? devWriteOut : 3'h7;
  assign priorityN = hostPriorityN;
  assign autovectorN = hostAutovectorN;
  assign coreDisablePin = hostCoreDisable;

  modport device (
    output devBusGrantN, devGrantAckOut, devGrantAckOeN, devStrobeOut, devStrobeOeN,
    output devFcOut, devFcOeN, devAckOut, devAckOeN, devWriteOut, devWriteOeN,
    input busRequestN, haltN, grantAckN, addressStrobeN, functionCode, transferAckN,
    input priorityN, autovectorN, coreDisablePin
  );

  modport master (
    output hostBusRequestOeN, hostHaltOeN, hostGrantAckOut, hostGrantAckOeN,
    output hostStrobeOut, hostStrobeOeN, hostFcOut, hostFcOeN, hostAckOut, hostAckOeN,
    output hostPriorityN, hostAutovectorN, hostCoreDisable,
    input busGrantN, grantAckN, addressStrobeN, haltN, transferAckN, writeStrobesN
  );
endinterface

// file: hw/bai_device_end.sv
// Purpose: device end - on-chip arbiter, interrupt pin decode, bus pin ownership
// Assumes: one clock; every pin input passes two flip-flops first
// Notes: the mode strap is caught only while totalReset is high
`timescale 1ns/1ps
`include "bai_cfg.svh"

module bai_device_end
  import bai_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  bai_link_if.device link,
  input wire logic totalReset,
  input wire logic dedicatedMode,
  input wire logic [1:0] edgeSense,
  input wire logic intAck,
  input wire logic [2:0] intAckLevel,
  input wire logic iackCycle,
  input wire logic sdmaReq,
  input wire logic idmaReq,
  input wire logic coreBusFree,
  input wire logic internalStrobe,
  input wire logic [2:0] coreFc,
  input wire logic [2:0] sdmaFc,
  input wire logic [2:0] idmaFc,
  input wire logic autoAck,
  input wire logic [2:0] writeReq,
  output logic coreDisabled,
  output logic sdmaGrant,
  output logic idmaGrant,
  output logic busClearReq,
  output logic extOwnsBus,
  output logic internalAccessOk,
  output logic [2:0] intLevel,
  output logic useAutovector,
  output logic [2:0] fcDecode,
  output logic ackSeen
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int SYNC_W = 13;
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  assign pinRaw = {link.coreDisablePin, link.priorityN, link.autovectorN,
                   link.functionCode, link.transferAckN, link.addressStrobeN,
                   link.grantAckN, link.haltN, link.busRequestN};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= '1;
      syncB <= '1;
    end else begin
      syncA <= pinRaw;
      syncB <= syncA;
    end
  end

  logic brSeen;
  logic haltSeen;
  logic gaSeen;
  logic asSeen;
  logic ackPinLow;
  logic [2:0] fcPin;
  logic avecSeen;
  logic [2:0] prioLow;
  logic strapPin;
  assign brSeen = !syncB[0];
  assign haltSeen = !syncB[1];
  assign gaSeen = !syncB[2];
  assign asSeen = !syncB[3];
  assign ackPinLow = !syncB[4];
  assign fcPin = syncB[7:5];
  assign avecSeen = !syncB[8];
  assign prioLow = ~syncB[11:9];
  assign strapPin = syncB[12];

  // ****************************************************************
  // mode strap
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coreDisabled <= 1'b0;
    end else if (totalReset) begin
      coreDisabled <= strapPin;
    end
  end

  // ****************************************************************
  // arbiter
  // ****************************************************************
  bai_dev_state_t state;
  bai_dev_state_t next_state;
  logic busGrant;
  logic cycleBusy;
  logic dmaMayGo;
  logic driveBus;

  // our own strobe shows on the synced pin too, so it also counts as busy
  assign cycleBusy = internalStrobe || asSeen;
  // an enabled core gives the bus to a DMA channel only after the bus clear handshake
  assign dmaMayGo = coreDisabled || coreBusFree;
  // taken from the next state so the pins float on the same edge the master
  // may start driving after its halt settle time
  assign driveBus = (next_state == BAI_DEV_INDEPENDENT_DMA_MASTER) || (next_state == BAI_DEV_SERIAL_DMA_MASTER) ||
                    (next_state == BAI_DEV_IDLE && !coreDisabled);

  always_comb begin
    next_state = state;
    case (state)
      BAI_DEV_IDLE: begin
        if (!cycleBusy) begin
          if (sdmaReq && dmaMayGo) begin
            next_state = BAI_DEV_SERIAL_DMA_MASTER;
          end else if (idmaReq && dmaMayGo) begin
            next_state = BAI_DEV_INDEPENDENT_DMA_MASTER;
          end else if (coreDisabled && busGrant && gaSeen) begin
            next_state = BAI_DEV_EXT;
          end else if (!coreDisabled && haltSeen) begin
            next_state = BAI_DEV_HALT;
          end
        end
      end
      BAI_DEV_INDEPENDENT_DMA_MASTER: begin
        if (!cycleBusy) begin
          if (sdmaReq) begin
            next_state = BAI_DEV_SERIAL_DMA_MASTER;
          end else if (!idmaReq) begin
            next_state = BAI_DEV_IDLE;
          end
        end
      end
      BAI_DEV_SERIAL_DMA_MASTER: begin
        if (!cycleBusy && !sdmaReq) begin
          next_state = idmaReq ? BAI_DEV_INDEPENDENT_DMA_MASTER : BAI_DEV_IDLE;
        end
      end
      BAI_DEV_EXT: begin
        if (!gaSeen) begin
          next_state = BAI_DEV_IDLE;
        end
      end
      BAI_DEV_HALT: begin
        if (!haltSeen) begin
          next_state = BAI_DEV_IDLE;
        end
      end
      default: begin
        next_state = BAI_DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= BAI_DEV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // external grant: only with the bus free and no internal requester waiting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busGrant <= 1'b0;
    end else if (!coreDisabled || state != BAI_DEV_IDLE || !brSeen) begin
      busGrant <= 1'b0;
    end else if (!cycleBusy && !sdmaReq && !idmaReq && !gaSeen) begin
      busGrant <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdmaGrant <= 1'b0;
      idmaGrant <= 1'b0;
      extOwnsBus <= 1'b0;
      busClearReq <= 1'b0;
      internalAccessOk <= 1'b0;
    end else begin
      sdmaGrant <= next_state == BAI_DEV_SERIAL_DMA_MASTER;
      idmaGrant <= next_state == BAI_DEV_INDEPENDENT_DMA_MASTER;
      extOwnsBus <= next_state == BAI_DEV_EXT || next_state == BAI_DEV_HALT;
      busClearReq <= !coreDisabled && (sdmaReq || idmaReq);
      // enabled core keeps internal memory to itself; the sync stage lets an
      // external master run without regard to our clock
      internalAccessOk <= coreDisabled ? (next_state != BAI_DEV_IDLE) :
                          (next_state == BAI_DEV_IDLE);
    end
  end

  // ****************************************************************
  // bus pin drivers
  // ****************************************************************
  logic dmaOwns;
  assign dmaOwns = (state == BAI_DEV_INDEPENDENT_DMA_MASTER) || (state == BAI_DEV_SERIAL_DMA_MASTER);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.devBusGrantN <= `BAI_PIN_IDLE;
      link.devGrantAckOut <= `BAI_PIN_IDLE;
      link.devGrantAckOeN <= 1'b1;
    end else begin
      link.devBusGrantN <= !busGrant;
      // one flag over both DMA states, so a serial steal never drops it
      link.devGrantAckOut <= !(coreDisabled && dmaOwns);
      link.devGrantAckOeN <= !(coreDisabled && dmaOwns);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.devStrobeOut <= `BAI_PIN_IDLE;
      link.devStrobeOeN <= 1'b1;
      link.devWriteOut <= 3'h7;
      link.devWriteOeN <= 1'b1;
      link.devAckOut <= `BAI_PIN_IDLE;
      link.devAckOeN <= 1'b1;
    end else begin
      link.devStrobeOut <= !(driveBus && internalStrobe);
      link.devStrobeOeN <= !driveBus;
      link.devWriteOut <= ~writeReq;
      link.devWriteOeN <= !driveBus;
      link.devAckOut <= !autoAck;
      link.devAckOeN <= !autoAck;
    end
  end

  // codes change only between strobes so they stay valid through one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.devFcOut <= `BAI_FC_RST;
      link.devFcOeN <= 1'b1;
    end else begin
      link.devFcOeN <= !driveBus;
      if (!internalStrobe) begin
        case (state)
          BAI_DEV_SERIAL_DMA_MASTER: link.devFcOut <= sdmaFc;
          BAI_DEV_INDEPENDENT_DMA_MASTER: link.devFcOut <= idmaFc;
          default: link.devFcOut <= coreFc;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fcDecode <= `BAI_FC_RST;
      ackSeen <= 1'b0;
      useAutovector <= 1'b0;
    end else begin
      fcDecode <= driveBus ? link.devFcOut : fcPin;
      ackSeen <= !autoAck && ackPinLow;
      useAutovector <= iackCycle && avecSeen;
    end
  end

  // ****************************************************************
  // interrupt pins
  // ****************************************************************
  logic [2:0] prioPrev;
  logic [2:0] pend;
  logic [2:0] active;
  logic [2:0] ackLvl [3];
  assign ackLvl[0] = `BAI_LEVEL_ONE;
  assign ackLvl[1] = `BAI_LEVEL_SIX;
  assign ackLvl[2] = `BAI_LEVEL_SEVEN;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prioPrev <= 3'h0;
    end else begin
      prioPrev <= prioLow;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gen_irq
      logic edgeMode;
      // the top input has no level option
      assign edgeMode = (gi == 2) ? 1'b1 : edgeSense[gi];
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pend[gi] <= 1'b0;
        end else if (prioLow[gi] && !prioPrev[gi]) begin
          pend[gi] <= 1'b1; // set beats a same-cycle acknowledge
        end else if (intAck && intAckLevel == ackLvl[gi]) begin
          pend[gi] <= 1'b0;
        end
      end
      assign active[gi] = edgeMode ? pend[gi] : prioLow[gi];
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intLevel <= `BAI_LEVEL_NONE;
    end else if (coreDisabled) begin
      intLevel <= `BAI_LEVEL_NONE;
    end else if (!dedicatedMode) begin
      intLevel <= prioLow;
    end else if (active[2]) begin
      intLevel <= `BAI_LEVEL_SEVEN;
    end else if (active[1]) begin
      intLevel <= `BAI_LEVEL_SIX;
    end else if (active[0]) begin
      intLevel <= `BAI_LEVEL_ONE;
    end else begin
      intLevel <= `BAI_LEVEL_NONE;
    end
  end

endmodule

// file: hw/bai_master_end.sv
// Purpose: external end - bus master taking the bus, interrupt source
// Assumes: one clock; pins from the device pass two flip-flops
// Notes: with the core enabled the bus is taken by halt instead of request
`timescale 1ns/1ps
`include "bai_cfg.svh"
module bai_master_end
  import bai_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  bai_link_if.master link,
  input wire logic coreDisableStrap,
  input wire logic wantBus,
  input wire logic busCycle,
  input wire logic [2:0] hostFc,
  input wire logic [2:0] irqLevel,
  input wire logic irqIack,
  input wire logic autovecReq,
  input wire logic respondAck,
  output logic ownsBus,
  output logic irqHeld
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] syncA;
  logic [2:0] syncB;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= 3'h7;
      syncB <= 3'h7;
    end else begin
      syncA <= {link.addressStrobeN, link.grantAckN, link.busGrantN};
      syncB <= syncA;
    end
  end

  logic bgSeen;
  logic gaSeen;
  logic asSeen;
  assign bgSeen = !syncB[0];
  assign gaSeen = !syncB[1];
  assign asSeen = !syncB[2];

  // ****************************************************************
  // bus ownership
  // ****************************************************************
  bai_host_state_t state;
  logic [1:0] settle;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= BAI_HOST_IDLE;
      settle <= 2'h0;
    end else begin
      case (state)
        BAI_HOST_IDLE: begin
          if (wantBus) begin
            state <= coreDisableStrap ? BAI_HOST_REQ : BAI_HOST_HALT;
          end
        end
        BAI_HOST_REQ: begin
          if (bgSeen) begin
            state <= BAI_HOST_WAIT;
          end
        end
        BAI_HOST_WAIT: begin
          if (!asSeen && !gaSeen) begin
            state <= BAI_HOST_OWN;
          end
        end
        BAI_HOST_HALT: begin
          settle <= 2'h0;
          if (!asSeen) begin
            state <= BAI_HOST_SETTLE;
          end
        end
        BAI_HOST_SETTLE: begin
          // extra clocks let the device float its strobes
          if (asSeen) begin
            state <= BAI_HOST_HALT;
          end else if (settle == `BAI_HALT_SETTLE_CLKS - 2'h1) begin
            state <= BAI_HOST_OWN;
          end else begin
            settle <= settle + 2'h1;
          end
        end
        BAI_HOST_OWN: begin
          if (!wantBus && !busCycle) begin
            state <= BAI_HOST_IDLE;
          end
        end
        default: begin
          state <= BAI_HOST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.hostCoreDisable <= 1'b0;
      link.hostBusRequestOeN <= 1'b1;
      link.hostHaltOeN <= 1'b1;
      link.hostGrantAckOut <= `BAI_PIN_IDLE;
      link.hostGrantAckOeN <= 1'b1;
      ownsBus <= 1'b0;
    end else begin
      link.hostCoreDisable <= coreDisableStrap;
      link.hostBusRequestOeN <= !(state == BAI_HOST_REQ || state == BAI_HOST_WAIT);
      link.hostHaltOeN <= !(state == BAI_HOST_HALT || state == BAI_HOST_SETTLE ||
                            (state == BAI_HOST_OWN && !coreDisableStrap));
      link.hostGrantAckOut <= !(state == BAI_HOST_OWN && coreDisableStrap);
      link.hostGrantAckOeN <= !(state == BAI_HOST_OWN && coreDisableStrap);
      ownsBus <= state == BAI_HOST_OWN;
    end
  end

  // codes only change while the strobe is high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.hostStrobeOut <= `BAI_PIN_IDLE;
      link.hostStrobeOeN <= 1'b1;
      link.hostFcOut <= `BAI_FC_RST;
      link.hostFcOeN <= 1'b1;
      link.hostAckOut <= `BAI_PIN_IDLE;
      link.hostAckOeN <= 1'b1;
    end else begin
      link.hostStrobeOut <= !(state == BAI_HOST_OWN && busCycle);
      link.hostStrobeOeN <= state != BAI_HOST_OWN;
      link.hostFcOeN <= state != BAI_HOST_OWN;
      if (link.hostStrobeOut) begin
        link.hostFcOut <= hostFc;
      end
      link.hostAckOut <= !respondAck;
      link.hostAckOeN <= !respondAck;
    end
  end

  // ****************************************************************
  // interrupt source
  // ****************************************************************
  logic [2:0] heldLevel;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      heldLevel <= `BAI_LEVEL_NONE;
      irqHeld <= 1'b0;
      link.hostPriorityN <= 3'h7;
      link.hostAutovectorN <= `BAI_PIN_IDLE;
    end else begin
      if (irqHeld && irqIack) begin
        irqHeld <= 1'b0;
        heldLevel <= `BAI_LEVEL_NONE;
      end else if (!irqHeld && irqLevel != `BAI_LEVEL_NONE) begin
        irqHeld <= 1'b1;
        heldLevel <= irqLevel;
      end
      link.hostPriorityN <= ~heldLevel;
      link.hostAutovectorN <= !(autovecReq && irqIack);
    end
  end

endmodule

// file: verif/bai_link_checker.sv
// Purpose: wire-level checks on the link between the two ends
// Assumes: one clock, reset active high
// Notes: host enables are watched so waits can be judged
`timescale 1ns/1ps
module bai_link_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic busRequestN,
  input wire logic busGrantN,
  input wire logic haltN,
  input wire logic grantAckN,
  input wire logic addressStrobeN,
  input wire logic [2:0] functionCode,
  input wire logic coreDisablePin,
  input wire logic devGrantAckOeN,
  input wire logic hostGrantAckOeN,
  input wire logic hostStrobeOeN,
  input wire logic devFcOeN,
  input wire logic hostFcOeN,
  input wire logic devWriteOeN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ****************************************
  // arbitration
  // ****************************************
  a_grant_core_off: assert property (!busGrantN |-> coreDisablePin)
    else $error("grant with core enabled");
  a_grant_needs_req: assert property (busRequestN [*8] |-> busGrantN)
    else $error("grant without request");
  a_gack_one_driver: assert property (!devGrantAckOeN |-> hostGrantAckOeN)
    else $error("grant ack driven by both");
  a_gack_no_gap: assert property ($rose(grantAckN) |=> grantAckN)
    else $error("grant ack glitched high");
  a_gack_after_grant: assert property ($fell(hostGrantAckOeN) |-> !busGrantN || !haltN)
    else $error("grant ack taken without grant");
  // ****************************************
  // bus pins
  // ****************************************
  a_fc_hold_strobe: assert property (!addressStrobeN && $past(!addressStrobeN)
    |-> $stable(functionCode))
    else $error("function code moved in strobe");
  a_fc_one_driver: assert property (!devFcOeN |-> hostFcOeN)
    else $error("function code driven by both");
  a_halt_float: assert property ((!haltN && addressStrobeN) [*8] |-> devWriteOeN)
    else $error("write pins driven under halt");
  a_halt_wait: assert property ($fell(hostStrobeOeN) && !haltN
    |-> $past(addressStrobeN) && $past(addressStrobeN, 2))
    else $error("master drove strobe too early");
endmodule

// file: verif/testbench.sv
// Purpose: both ends joined; interrupt table, then hand tests
// Assumes: inputs driven at falling edge
// Notes: waits are bounded polls
`timescale 1ns/1ps
module testbench;
  logic clk = 0, sys_rst = 1, totalReset = 1, dedicatedMode = 0, intAck = 0, iackCycle = 1;
  logic sdmaReq = 0, idmaReq = 0, coreBusFree = 0, internalStrobe = 0, autoAck = 0;
  logic coreDisableStrap = 0, wantBus = 0, busCycle = 0, irqIack = 0, autovecReq = 0;
  logic respondAck = 0;
  logic [1:0] edgeSense = 2'h1;
  logic [2:0] intAckLevel = 3'h0, coreFc = 3'h5, sdmaFc = 3'h6, idmaFc = 3'h1;
  logic [2:0] writeReq = 3'h0, hostFc = 3'h2, irqLevel = 3'h0, intLevel, fcDecode;
  logic coreDisabled, sdmaGrant, idmaGrant, busClearReq, extOwnsBus, internalAccessOk;
  logic useAutovector, ackSeen, ownsBus, irqHeld;
  // row: level, autovector, expected level, expected autovector
  logic [7:0] rows [8] = '{8'h00, 8'h33, 8'h44, 8'h77, 8'h88, 8'hBB, 8'hCC, 8'hFF};
  int fails = 0, n_compared = 0, k;
  always #20 clk = ~clk;
  bai_link_if link ();
  bai_device_end i_bai_device_end (.clk, .sys_rst, .link(link), .totalReset, .dedicatedMode,
    .edgeSense, .intAck, .intAckLevel, .iackCycle, .sdmaReq, .idmaReq, .coreBusFree,
    .internalStrobe, .coreFc, .sdmaFc, .idmaFc, .autoAck, .writeReq, .coreDisabled,
    .sdmaGrant, .idmaGrant, .busClearReq, .extOwnsBus, .internalAccessOk, .intLevel,
    .useAutovector, .fcDecode, .ackSeen);
  bai_master_end i_bai_master_end (.clk, .sys_rst, .link(link), .coreDisableStrap, .wantBus,
    .busCycle, .hostFc, .irqLevel, .irqIack, .autovecReq, .respondAck, .ownsBus, .irqHeld);
  bai_link_checker i_bai_link_checker (.clk, .sys_rst, .busRequestN(link.busRequestN),
    .busGrantN(link.busGrantN), .haltN(link.haltN), .grantAckN(link.grantAckN),
    .addressStrobeN(link.addressStrobeN), .functionCode(link.functionCode),
    .coreDisablePin(link.coreDisablePin), .devGrantAckOeN(link.devGrantAckOeN),
    .hostGrantAckOeN(link.hostGrantAckOeN), .hostStrobeOeN(link.hostStrobeOeN),
    .devFcOeN(link.devFcOeN), .hostFcOeN(link.hostFcOeN), .devWriteOeN(link.devWriteOeN));
  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // strap is caught only while totalReset stays high past sys_rst
  task automatic rst(input logic s);
    coreDisableStrap = s;
    sys_rst = 1;
    totalReset = 1;
    cyc(4);
    sys_rst = 0;
    cyc(4);
    totalReset = 0;
    cyc(2);
  endtask
  // clear the source first so the new level is latched cleanly
  task automatic irq(input logic [2:0] l);
    irqLevel = 3'h0;
    irqIack = 1;
    cyc(1);
    irqIack = 0;
    irqLevel = l;
    cyc(8);
  endtask
  task automatic ack(input logic [2:0] l);
    intAck = 1;
    intAckLevel = l;
    cyc(1);
    intAck = 0;
    cyc(3);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #120000;
    fails++;
    summarize();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst(1'b0);
    chk(coreDisabled, 3'h0);
    chk(fcDecode, coreFc);
    chk(internalAccessOk, 3'h1);
    foreach (rows[i]) begin
      autovecReq = rows[i][4];
      irq(rows[i][7:5]);
      chk(intLevel, rows[i][3:1]);
      irqLevel = 3'h0;
      irqIack = 1;
      cyc(4);
      chk(useAutovector, rows[i][0]);
      irqIack = 0;
    end
    autovecReq = 0;
    ack(3'h7);
    ack(3'h1);
    dedicatedMode = 1;
    irq(3'h3);
    chk(intLevel, 3'h6);
    chk(irqHeld, 3'h1);
    irq(3'h0);
    chk(intLevel, 3'h1);
    ack(3'h1);
    chk(intLevel, 3'h0);
    irq(3'h4);
    irq(3'h0);
    chk(intLevel, 3'h7);
    ack(3'h7);
    chk(intLevel, 3'h0);
    dedicatedMode = 0;
    autoAck = 1;
    cyc(3);
    chk(link.transferAckN, 3'h0);
    autoAck = 0;
    idmaReq = 1;
    cyc(8);
    chk(busClearReq, 3'h1);
    chk(idmaGrant, 3'h0);
    coreBusFree = 1;
    for (k = 0; k < 40 && idmaGrant !== 1'b1; k++) cyc(1);
    cyc(2);
    chk(fcDecode, idmaFc);
    idmaReq = 0;
    coreBusFree = 0;
    cyc(8);
    writeReq = 3'h7;
    wantBus = 1;
    for (k = 0; k < 60 && ownsBus !== 1'b1; k++) cyc(1);
    busCycle = 1;
    cyc(6);
    chk(extOwnsBus, 3'h1);
    chk(link.writeStrobesN, 3'h7);
    chk(internalAccessOk, 3'h0);
    chk(fcDecode, hostFc);
    busCycle = 0;
    wantBus = 0;
    writeReq = 3'h0;
    cyc(12);
    rst(1'b1);
    chk(coreDisabled, 3'h1);
    irq(3'h5);
    chk(intLevel, 3'h0);
    irq(3'h0);
    internalStrobe = 1;
    idmaReq = 1;
    cyc(8);
    chk(idmaGrant, 3'h0);
    internalStrobe = 0;
    for (k = 0; k < 40 && idmaGrant !== 1'b1; k++) cyc(1);
    cyc(2);
    chk(link.grantAckN, 3'h0);
    chk(internalAccessOk, 3'h1);
    sdmaReq = 1;
    for (k = 0; k < 40 && sdmaGrant !== 1'b1; k++) cyc(1);
    cyc(2);
    chk(idmaGrant, 3'h0);
    chk(fcDecode, sdmaFc);
    chk(link.grantAckN, 3'h0);
    sdmaReq = 0;
    for (k = 0; k < 40 && idmaGrant !== 1'b1; k++) cyc(1);
    chk(idmaGrant, 3'h1);
    idmaReq = 0;
    cyc(8);
    wantBus = 1;
    for (k = 0; k < 60 && ownsBus !== 1'b1; k++) cyc(1);
    cyc(4);
    chk(extOwnsBus, 3'h1);
    chk(link.grantAckN, 3'h0);
    respondAck = 1;
    sdmaReq = 1;
    cyc(8);
    chk(ackSeen, 3'h1);
    chk(sdmaGrant, 3'h0);
    respondAck = 0;
    wantBus = 0;
    for (k = 0; k < 60 && sdmaGrant !== 1'b1; k++) cyc(1);
    chk(sdmaGrant, 3'h1);
    sdmaReq = 0;
    coreDisableStrap = 0;
    cyc(8);
    chk(coreDisabled, 3'h1);
    summarize();
  end
endmodule
